// File: logic/lin_link_pkg.sv
// Purpose: Shared constants and types for the slave link transmit path.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes: All offsets and field positions, and the baud reset value, live here.

package lin_link_pkg;

	// ------------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int BAUD_W = 16;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] OFS_LINK_CONFIG = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_LINK_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_LINK_DATA = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_BAUD_UPPER = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_BAUD_LOWER = 5'h10;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	// Link config register.
	localparam int CFG_HALT_BIT = 0;
	localparam int CFG_LOCKOUT_BIT = 1;
	localparam int CFG_TIMER_EN_BIT = 2;
	localparam int CFG_RX_EN_BIT = 3;
	localparam int CFG_RX_ACT_BIT = 4;
	localparam int CFG_TX_RUN_BIT = 5;
	// Link status register.
	localparam int ST_OVERFLOW_BIT = 0;
	localparam int ST_RX_LOADED_BIT = 1;
	localparam int ST_TX_VACANT_BIT = 2;
	localparam int ST_WR_COLL_BIT = 3;
	localparam int ST_CLASH_BIT = 4;
	localparam int ST_DRV_OFF_BIT = 5;
	localparam int ST_SYNC_BIT = 6;

	// ------------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------------
	localparam logic [BAUD_W-1:0] BAUD_RESET = 16'h0000;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

	// Transmitter sequencing.
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_STOP,
		TX_START,
		TX_DATA
	} tx_state_type;

	// Complete state of the block.
	typedef struct packed {
		logic rx_meta;
		logic rx_sync;
		logic rx_prev;
		logic waitreq;
		logic [DATA_W-1:0] rdata;
		logic halt;
		logic lockout;
		logic timer_en;
		logic rx_en;
		logic rx_act;
		logic tx_run;
		logic ovf;
		logic rx_loaded;
		logic tx_vacant;
		logic wr_coll;
		logic clash;
		logic drv_off;
		logic sync_flag;
		logic [BAUD_W-1:0] baud;
		logic [7:0] rx_buf;
		logic [7:0] rx_shift;
		logic [3:0] rx_cnt;
		logic [BAUD_W:0] rx_timer;
		logic [7:0] tx_buf;
		logic [7:0] tx_shift;
		logic [3:0] tx_cnt;
		logic [BAUD_W-1:0] tx_timer;
		tx_state_type tx_state;
		logic tx_line;
	} state_type;

endpackage

// File: logic/lin_slave_transmit_path.sv
// Purpose: Transmit path of a single-wire slave link with receiver control.
// Assumes: Header detector on the same clock; receive line is a pin.
// Notes: Registers reached over Avalon-MM with waitrequest.
//
// Operation
// - Data write disables receiver, starts transmitter.
// - Vacant drops on write, returns when the byte moves to the shifter.
// - Write while full: keep old, flag collision.
// - Status read clears write collision flag.
// - Send leading one, zero start, eight data.
// - Continue with next byte, else stop running.
// - Clash: active receiver, edge, zero-for-one.
// - Clash stops transmitter, empties buffer, flags.
// - Bit end: zero sent, one seen means shutdown.
// - Shutdown stops transmitter, empties buffer, flags.
// - Sync strobe always deactivates the transmitter.
// - Reset: receiver unlocked but disabled until a header, idle timer disabled.
// - Zero stop bit disables receiver until sync.
// - Data port: read receive byte, write transmit.
// - Baud value is upper and lower concatenated.
// - Start, eight data, stop; sample mid-bit.
// - Halt strobe self-clears, resets receive control.
// - Header loads baud, enables receiver, flags sync.
//
// The Avalon-MM register port and the register addresses were decided locally.

`timescale 1ns/1ps

module lin_slave_transmit_path
	import lin_link_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Avalon-MM register slave.
	input wire logic [ADDR_W-1:0] avm_address,
	input wire logic avm_read,
	input wire logic avm_write,
	input wire logic [DATA_W-1:0] avm_writedata,
	output logic [DATA_W-1:0] avm_readdata,
	output logic avm_waitrequest,
	// Header detector, same clock.
	input wire logic sync_strobe,
	input wire logic [BAUD_W-1:0] detected_baud,
	// Transceiver pins.
	input wire logic rx_line,
	output logic tx_line,
	// Inactivity timer control.
	output logic idle_timer_enable
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	state_type s_reg; // Registered state.
	state_type s_next; // Next state.

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// One combinational pass; later sections override earlier ones, so
	// the order below is the priority order, with hardware sets last.
	always_comb begin
		logic fall; // Falling edge on the synchronised line.
		logic [BAUD_W-1:0] bit_last; // Last count of one bit period.
		logic tx_bit_end; // Current transmit bit ends here.
		logic clash_ev; // Bus clash seen this cycle.
		logic drv_ev; // Transceiver shutdown seen this cycle.
		logic ovf_ev; // Receive overflow this cycle.
		logic load_ev; // Received byte lands in the buffer this cycle.
		logic access; // New bus request taken this cycle.
		s_next = s_reg;
		clash_ev = 1'b0;
		drv_ev = 1'b0;
		ovf_ev = 1'b0;
		load_ev = 1'b0;
		// A zero baud value would stall the counters; run one cycle per bit.
		bit_last = (s_reg.baud == BAUD_RESET) ? BAUD_RESET :
			s_reg.baud - 16'h0001;
		tx_bit_end = (s_reg.tx_timer == bit_last);
		// Only the second synchroniser stage and later feed logic.
		fall = s_reg.rx_prev & ~s_reg.rx_sync;
		access = s_reg.waitreq & (avm_read | avm_write);
		s_next.rx_meta = rx_line;
		s_next.rx_sync = s_reg.rx_meta;
		s_next.rx_prev = s_reg.rx_sync;
		s_next.halt = 1'b0;

		// --------------------------------------------------------------
		// Receiver
		// --------------------------------------------------------------
		if (s_reg.rx_act) begin
			if (s_reg.rx_timer == '0) begin
				s_next.rx_timer = {1'b0, bit_last};
				if (s_reg.rx_cnt != DATA_BITS) begin
					s_next.rx_shift = {s_reg.rx_sync, s_reg.rx_shift[7:1]};
					s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
				end else begin
					// Middle of the stop bit: the byte is complete.
					s_next.rx_act = 1'b0;
					if (!s_reg.rx_sync) begin
						s_next.rx_en = 1'b0;
					end else if (s_reg.rx_loaded) begin
						ovf_ev = 1'b1;
					end else begin
						s_next.rx_buf = s_reg.rx_shift;
						// Set late so a data read in this cycle cannot hide it.
						load_ev = 1'b1;
					end
				end
			end else begin
				s_next.rx_timer = s_reg.rx_timer - 17'h00001;
			end
		end else if (s_reg.rx_en && fall) begin
			// Start edge: wait one and a half bits to the first data bit.
			s_next.rx_act = 1'b1;
			s_next.rx_cnt = 4'h0;
			s_next.rx_timer = {1'b0, bit_last} +
				{2'b00, s_reg.baud[BAUD_W-1:1]};
		end

		// --------------------------------------------------------------
		// Transmitter
		// --------------------------------------------------------------
		unique case (s_reg.tx_state)
			TX_IDLE: begin
				if (s_reg.tx_run && !s_reg.tx_vacant) begin
					s_next.tx_shift = s_reg.tx_buf;
					s_next.tx_vacant = 1'b1;
					s_next.tx_state = TX_STOP;
					s_next.tx_timer = BAUD_RESET;
					s_next.tx_line = 1'b1;
				end
			end
			TX_STOP: begin
				if (fall) begin
					clash_ev = 1'b1;
				end else if (tx_bit_end) begin
					s_next.tx_state = TX_START;
					s_next.tx_line = 1'b0;
					s_next.tx_timer = BAUD_RESET;
				end else begin
					s_next.tx_timer = s_reg.tx_timer + 16'h0001;
				end
			end
			TX_START: begin
				if (!tx_bit_end) begin
					s_next.tx_timer = s_reg.tx_timer + 16'h0001;
				end else if (s_reg.rx_sync) begin
					drv_ev = 1'b1;
				end else begin
					s_next.tx_state = TX_DATA;
					s_next.tx_line = s_reg.tx_shift[0];
					s_next.tx_cnt = 4'h0;
					s_next.tx_timer = BAUD_RESET;
				end
			end
			TX_DATA: begin
				if (!tx_bit_end) begin
					s_next.tx_timer = s_reg.tx_timer + 16'h0001;
				end else if (!s_reg.tx_line && s_reg.rx_sync) begin
					drv_ev = 1'b1;
				end else if (s_reg.tx_line && !s_reg.rx_sync) begin
					clash_ev = 1'b1;
				end else if (s_reg.tx_cnt == DATA_BITS - 4'h1) begin
					// Byte done; release the bus to recessive.
					s_next.tx_line = 1'b1;
					s_next.tx_timer = BAUD_RESET;
					if (!s_reg.tx_vacant) begin
						s_next.tx_shift = s_reg.tx_buf;
						s_next.tx_vacant = 1'b1;
						s_next.tx_state = TX_STOP;
					end else begin
						s_next.tx_run = 1'b0;
						s_next.tx_state = TX_IDLE;
					end
				end else begin
					s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
					s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
					s_next.tx_line = s_reg.tx_shift[1];
					s_next.tx_timer = BAUD_RESET;
				end
			end
		endcase

		// --------------------------------------------------------------
		// Register slave
		// --------------------------------------------------------------
		// A request is served at the edge where waitrequest is high and
		// answered one cycle later with waitrequest low.
		s_next.waitreq = ~access;
		if (access) begin
			s_next.rdata = READ_ZERO;
		end
		if (access && avm_read) begin
			unique case (avm_address)
				OFS_LINK_CONFIG: begin
					s_next.rdata[CFG_HALT_BIT] = s_reg.halt;
					s_next.rdata[CFG_LOCKOUT_BIT] = s_reg.lockout;
					s_next.rdata[CFG_TIMER_EN_BIT] = s_reg.timer_en;
					s_next.rdata[CFG_RX_EN_BIT] = s_reg.rx_en;
					s_next.rdata[CFG_RX_ACT_BIT] = s_reg.rx_act;
					s_next.rdata[CFG_TX_RUN_BIT] = s_reg.tx_run;
				end
				OFS_LINK_STATUS: begin
					s_next.rdata[ST_OVERFLOW_BIT] = s_reg.ovf;
					s_next.rdata[ST_RX_LOADED_BIT] = s_reg.rx_loaded;
					s_next.rdata[ST_TX_VACANT_BIT] = s_reg.tx_vacant;
					s_next.rdata[ST_WR_COLL_BIT] = s_reg.wr_coll;
					s_next.rdata[ST_CLASH_BIT] = s_reg.clash;
					s_next.rdata[ST_DRV_OFF_BIT] = s_reg.drv_off;
					s_next.rdata[ST_SYNC_BIT] = s_reg.sync_flag;
					s_next.wr_coll = 1'b0;
				end
				OFS_LINK_DATA: begin
					s_next.rdata[7:0] = s_reg.rx_buf;
					s_next.rx_loaded = 1'b0;
				end
				OFS_BAUD_UPPER: begin
					s_next.rdata[7:0] = s_reg.baud[15:8];
				end
				OFS_BAUD_LOWER: begin
					s_next.rdata[7:0] = s_reg.baud[7:0];
				end
				default: begin
					// Unmapped addresses read as zero.
				end
			endcase
		end
		if (access && avm_write) begin
			unique case (avm_address)
				OFS_LINK_CONFIG: begin
					s_next.halt = avm_writedata[CFG_HALT_BIT];
					s_next.lockout = avm_writedata[CFG_LOCKOUT_BIT];
					s_next.timer_en = avm_writedata[CFG_TIMER_EN_BIT];
				end
				OFS_LINK_STATUS: begin
					// Sticky event flags other than write collision clear by writing one.
					if (avm_writedata[ST_OVERFLOW_BIT]) s_next.ovf = 1'b0;
					if (avm_writedata[ST_CLASH_BIT]) s_next.clash = 1'b0;
					if (avm_writedata[ST_DRV_OFF_BIT]) s_next.drv_off = 1'b0;
					if (avm_writedata[ST_SYNC_BIT]) s_next.sync_flag = 1'b0;
				end
				OFS_LINK_DATA: begin
					if (s_reg.tx_vacant) begin
						s_next.tx_buf = avm_writedata[7:0];
						s_next.tx_vacant = 1'b0;
						s_next.rx_en = 1'b0;
						s_next.rx_act = 1'b0;
						s_next.tx_run = 1'b1;
						if (s_reg.rx_act) clash_ev = 1'b1;
					end else begin
						s_next.wr_coll = 1'b1;
					end
				end
				OFS_BAUD_UPPER: begin
					s_next.baud[15:8] = avm_writedata[7:0];
				end
				OFS_BAUD_LOWER: begin
					s_next.baud[7:0] = avm_writedata[7:0];
				end
				default: begin
					// Unmapped writes are ignored.
				end
			endcase
		end

		// --------------------------------------------------------------
		// Receiver halt, error aborts, header sync
		// --------------------------------------------------------------
		if (s_reg.halt) begin
			s_next.rx_en = 1'b0;
			s_next.rx_act = 1'b0;
			s_next.rx_cnt = 4'h0;
			s_next.rx_timer = '0;
		end
		// Flags set after the clears so that an event is never lost.
		if (ovf_ev) s_next.ovf = 1'b1;
		if (load_ev) s_next.rx_loaded = 1'b1;
		if (clash_ev || drv_ev || sync_strobe) begin
			s_next.tx_run = 1'b0;
			s_next.tx_vacant = 1'b1;
			s_next.tx_state = TX_IDLE;
			s_next.tx_line = 1'b1;
		end
		if (clash_ev) s_next.clash = 1'b1;
		if (drv_ev) s_next.drv_off = 1'b1;
		// A locked-out receiver ignores headers; the transmitter abort above still happens.
		if (sync_strobe && !s_reg.lockout) begin
			s_next.baud = detected_baud;
			s_next.rx_en = 1'b1;
			s_next.rx_act = 1'b0;
			s_next.rx_cnt = 4'h0;
			s_next.sync_flag = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Synchronous reset; every field takes a constant.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.rx_meta <= 1'b1;
			s_reg.rx_sync <= 1'b1;
			s_reg.rx_prev <= 1'b1;
			s_reg.waitreq <= 1'b1;
			s_reg.lockout <= 1'b0;
			s_reg.timer_en <= 1'b0;
			s_reg.tx_vacant <= 1'b1;
			s_reg.baud <= BAUD_RESET;
			s_reg.tx_state <= TX_IDLE;
			s_reg.tx_line <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign avm_readdata = s_reg.rdata;
	assign avm_waitrequest = s_reg.waitreq;
	assign tx_line = s_reg.tx_line;
	assign idle_timer_enable = s_reg.timer_en;

endmodule // lin_slave_transmit_path

// File: tb/lin_bus_model.sv
// Purpose: Bus and transceiver model behind the link pins.
// Assumes: Pull-up bus, one cycle of loopback delay.
// Notes: Other nodes pull dominant; a cut driver leaves the bus high.
`timescale 1ns/1ps
module lin_bus_model (
	// Clock.
	input wire logic clock,
	// Pins and fault controls.
	input wire logic tx_line,
	input wire logic dom_req,
	input wire logic drv_cut,
	output logic rx_line
);
	always_ff @(posedge clock) begin
		rx_line <= (tx_line | drv_cut) & ~dom_req;
	end
endmodule // lin_bus_model

// File: tb/lin_link_asserts.sv
// Purpose: Port checks on the slave link transmit path.
// Assumes: One clock, synchronous active-high reset.
// Notes: The bit period is shadowed from accepted strobes and baud writes.
`timescale 1ns/1ps
module lin_link_asserts
	import lin_link_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Register bus.
	input wire logic [ADDR_W-1:0] avm_address,
	input wire logic avm_read,
	input wire logic avm_write,
	input wire logic [DATA_W-1:0] avm_writedata,
	input wire logic [DATA_W-1:0] avm_readdata,
	input wire logic avm_waitrequest,
	// Header and pins.
	input wire logic sync_strobe,
	input wire logic [BAUD_W-1:0] detected_baud,
	input wire logic rx_line,
	input wire logic tx_line,
	input wire logic idle_timer_enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic take;
	logic cfg_wr;
	logic [BAUD_W-1:0] baud_reg;
	logic lock_reg;
	logic [BAUD_W:0] high_reg;
	logic [BAUD_W:0] miss_reg;
	logic [BAUD_W:0] period;
	assign take = (avm_read | avm_write) & avm_waitrequest;
	assign cfg_wr = take & avm_write & (avm_address == OFS_LINK_CONFIG);
	assign period = (baud_reg == '0) ? 17'h1 : {1'b0, baud_reg};
	// Shadow period; count high cycles and sent-low-seen-high cycles.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			baud_reg <= '0;
			lock_reg <= 1'b0;
			high_reg <= '0;
			miss_reg <= '0;
		end else begin
			if (cfg_wr) lock_reg <= avm_writedata[CFG_LOCKOUT_BIT];
			if (take && avm_write && avm_address == OFS_BAUD_UPPER)
				baud_reg[15:8] <= avm_writedata[7:0];
			if (take && avm_write && avm_address == OFS_BAUD_LOWER)
				baud_reg[7:0] <= avm_writedata[7:0];
			// A locked-out receiver keeps its period across headers.
			if (sync_strobe && !lock_reg) baud_reg <= detected_baud;
			high_reg <= tx_line ? high_reg + 17'h1 : '0;
			miss_reg <= (!tx_line && rx_line) ? miss_reg + 17'h1 : '0;
		end
	end
	sequence s_answer;
		!avm_waitrequest ##1 avm_waitrequest;
	endsequence
	AST_BUS_ANSWER: assert property (take |=> s_answer)
		else $error("answer not one cycle");
	AST_BUS_CAUSE: assert property (
		$fell(avm_waitrequest) |-> $past(take))
		else $error("answer without request");
	AST_UNMAPPED_ZERO: assert property (
		take && avm_read && avm_address > OFS_BAUD_LOWER
		|=> avm_readdata == READ_ZERO)
		else $error("unmapped read not zero");
	AST_SYNC_ABORT: assert property (sync_strobe |=> tx_line [*3])
		else $error("sync did not release line");
	AST_TIMER_CAUSE: assert property (
		$changed(idle_timer_enable) |-> $past(cfg_wr) || $past(cfg_wr, 2))
		else $error("timer enable changed alone");
	AST_DRIVER_CUT: assert property (miss_reg <= period + 17'h3)
		else $error("sent low too long with line high");
	AST_LEAD_STOP: assert property (
		$fell(tx_line) |-> high_reg >= period)
		else $error("start bit too early");
	AST_RESET_STATE: assert property (
		$past(sys_rst) |-> tx_line && avm_waitrequest && !idle_timer_enable)
		else $error("bad state after reset");
endmodule // lin_link_asserts

bind lin_slave_transmit_path lin_link_asserts lin_link_asserts_inst (
	.clock(clock), .sys_rst(sys_rst), .avm_address(avm_address),
	.avm_read(avm_read), .avm_write(avm_write),
	.avm_writedata(avm_writedata), .avm_readdata(avm_readdata),
	.avm_waitrequest(avm_waitrequest), .sync_strobe(sync_strobe),
	.detected_baud(detected_baud), .rx_line(rx_line), .tx_line(tx_line),
	.idle_timer_enable(idle_timer_enable)
);

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the slave link transmit path.
// Assumes: Bit period from header strobes or baud writes.
// Notes: Reads and sent bytes are queued and compared by monitors.
`timescale 1ns/1ps
module tb_top
	import lin_link_pkg::*;
;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] avm_address = '0;
	logic avm_read = 1'b0;
	logic avm_write = 1'b0;
	logic [DATA_W-1:0] avm_writedata = '0;
	logic [DATA_W-1:0] avm_readdata;
	logic avm_waitrequest;
	logic sync_strobe = 1'b0;
	logic [BAUD_W-1:0] detected_baud = '0;
	logic rx_line;
	logic tx_line;
	logic idle_timer_enable;
	logic dom_req = 1'b0;
	logic drv_cut = 1'b0;
	logic dec_on = 1'b0;
	logic [7:0] dec_byte;
	logic [7:0] rnd_byte;
	logic [DATA_W-1:0] exp_q[$];
	logic [DATA_W-1:0] msk_q[$];
	logic [DATA_W-1:0] msk;
	logic [7:0] byte_q[$];
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	int p = 1;
	always #25 clock = ~clock;
	lin_slave_transmit_path lin_slave_transmit_path_inst (
		.clock(clock), .sys_rst(sys_rst), .avm_address(avm_address),
		.avm_read(avm_read), .avm_write(avm_write),
		.avm_writedata(avm_writedata), .avm_readdata(avm_readdata),
		.avm_waitrequest(avm_waitrequest), .sync_strobe(sync_strobe),
		.detected_baud(detected_baud), .rx_line(rx_line),
		.tx_line(tx_line), .idle_timer_enable(idle_timer_enable)
	);
	lin_bus_model lin_bus_model_inst (
		.clock(clock), .tx_line(tx_line), .dom_req(dom_req),
		.drv_cut(drv_cut), .rx_line(rx_line)
	);
	task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Hold the request until waitrequest is seen low, then idle a cycle.
	task automatic bus(input logic is_wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		avm_address <= a;
		avm_write <= is_wr;
		avm_read <= ~is_wr;
		avm_writedata <= d;
		do @(posedge clock); while (avm_waitrequest !== 1'b0);
		avm_read <= 1'b0;
		avm_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input logic [DATA_W-1:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, '0);
	endtask
	task automatic hdr(input logic [BAUD_W-1:0] b);
		sync_strobe <= 1'b1;
		detected_baud <= b;
		@(posedge clock);
		sync_strobe <= 1'b0;
		@(posedge clock);
	endtask
	// Another node sends a frame with the given stop level.
	task automatic rx_byte(input logic [7:0] v, input logic s);
		logic [9:0] f;
		f = {s, v, 1'b0};
		for (int j = 0; j < 10; j++) begin
			dom_req <= ~f[j];
			wt(p);
		end
		dom_req <= 1'b0;
		wt(p);
	endtask
	// Read monitor and run limit.
	always @(posedge clock) begin
		cyc++;
		if (avm_read === 1'b1 && avm_waitrequest === 1'b0) begin
			msk = msk_q.pop_front();
			chk(avm_readdata & msk, exp_q.pop_front());
		end
		if (cyc == 6000) begin
			failures++;
			finish_test();
		end
	end
	// Line decoder: sample each bit in its middle.
	always begin
		@(negedge tx_line);
		if (dec_on) begin
			repeat (p / 2) @(posedge clock);
			for (int j = 0; j < 8; j++) begin
				repeat (p) @(posedge clock);
				dec_byte[j] = tx_line;
			end
			repeat (p) @(posedge clock);
			chk({24'h0, dec_byte}, {24'h0, byte_q.pop_front()});
			chk({31'h0, tx_line}, 32'h1);
		end
	end
	initial begin
		void'($urandom(32'h945810E7));
		wt(12);
		sys_rst <= 1'b0;
		wt(1);
		rd(OFS_LINK_CONFIG, 32'h0, 32'h3F);
		rd(OFS_LINK_STATUS, 32'h4, 32'h7F);
		hdr(16'h0008);
		p = 8;
		rd(OFS_LINK_STATUS, 32'h40, 32'h40);
		rd(OFS_LINK_CONFIG, 32'h8, 32'h18);
		bus(1'b1, OFS_LINK_STATUS, 32'h40);
		rd(OFS_LINK_STATUS, 32'h0, 32'h40);
		// Two bytes back to back, a third collides.
		dec_on = 1'b1;
		repeat (2) begin
			rnd_byte = 8'($urandom);
			byte_q.push_back(rnd_byte);
			bus(1'b1, OFS_LINK_DATA, {24'h0, rnd_byte});
		end
		bus(1'b1, OFS_LINK_DATA, $urandom);
		rd(OFS_LINK_STATUS, 32'h8, 32'hC);
		rd(OFS_LINK_STATUS, 32'h0, 32'h8);
		rd(OFS_LINK_CONFIG, 32'h20, 32'h38);
		wt(24 * p);
		rd(OFS_LINK_CONFIG, 32'h0, 32'h20);
		dec_on = 1'b0;
		// Clash in stop bit, in data, and with an active receiver.
		for (int k = 0; k < 3; k++) begin
			if (k == 2) begin
				hdr(16'h0008);
				dom_req <= 1'b1;
				wt(4);
			end
			bus(1'b1, OFS_LINK_DATA, 32'hFF);
			wt(k == 1 ? 3 * p : 0);
			dom_req <= 1'b1;
			wt(p + 2);
			dom_req <= 1'b0;
			wt(4 * p);
			rd(OFS_LINK_STATUS, 32'h14, 32'h14);
			rd(OFS_LINK_CONFIG, 32'h0, 32'h20);
			bus(1'b1, OFS_LINK_STATUS, 32'h50);
		end
		drv_cut <= 1'b1;
		bus(1'b1, OFS_LINK_DATA, 32'h0);
		wt(4 * p);
		rd(OFS_LINK_STATUS, 32'h24, 32'h24);
		rd(OFS_LINK_CONFIG, 32'h0, 32'h20);
		drv_cut <= 1'b0;
		bus(1'b1, OFS_LINK_DATA, 32'hAA);
		wt(2 * p);
		hdr(16'h0008);
		rd(OFS_LINK_CONFIG, 32'h8, 32'h28);
		bus(1'b1, OFS_LINK_CONFIG, 32'h1);
		rd(OFS_LINK_CONFIG, 32'h0, 32'h19);
		bus(1'b1, 5'h14, 32'hFFFFFFFF);
		rd(5'h14, 32'h0, 32'hFFFFFFFF);
		// Receive one good byte, then one with a low stop bit.
		hdr(16'h0008);
		rnd_byte = 8'($urandom);
		rx_byte(rnd_byte, 1'b1);
		rd(OFS_LINK_STATUS, 32'h2, 32'h2);
		rd(OFS_LINK_DATA, {24'h0, rnd_byte}, 32'hFF);
		rx_byte(8'h55, 1'b0);
		rd(OFS_LINK_CONFIG, 32'h0, 32'h8);
		// Transmit-only use with a written period.
		bus(1'b1, OFS_LINK_CONFIG, 32'h6);
		chk({31'h0, idle_timer_enable}, 32'h1);
		bus(1'b1, OFS_LINK_CONFIG, 32'h2);
		bus(1'b1, OFS_BAUD_UPPER, 32'h0);
		bus(1'b1, OFS_BAUD_LOWER, 32'h6);
		rd(OFS_BAUD_LOWER, 32'h6, 32'hFF);
		rd(OFS_BAUD_UPPER, 32'h0, 32'hFF);
		p = 6;
		dec_on = 1'b1;
		byte_q.push_back(8'hC3);
		bus(1'b1, OFS_LINK_DATA, 32'hC3);
		wt(16 * p);
		dec_on = 1'b0;
		hdr(16'h0008);
		rd(OFS_LINK_CONFIG, 32'h2, 32'hA);
		sys_rst <= 1'b1;
		wt(2);
		sys_rst <= 1'b0;
		wt(1);
		rd(OFS_LINK_CONFIG, 32'h0, 32'h3F);
		finish_test();
	end
endmodule // tb_top
